/* core/dual_timer_counter_control.sv */
// module: two 16-bit timer/counters with control/status, mode register and external irq sense
// Function
// - per external irq, a type bit selects falling edge or low level request
// - falling edge on irq pin sets edge flag; cleared when interrupt is processed
// - run bit per timer; when cleared timer stops and holds value (here timer 1 ignores its run bit while timer 0 is in split mode)
// - hardware sets overflow flag on overflow; only software clears it (here timer0_ack and timer1_ack also clear it)
// - in timer 0 split mode, timer 1 run bit gates timer 0 high byte
// - in timer 0 split mode, timer 0 high byte overflow sets timer 1 flag
// - each timer is read and written as separate high and low bytes
// - internal reset zeroes mode, control and all four count bytes
// - reset pin held high two machine cycles; internal reset during the second
// - timer counts each machine cycle; counter counts count-pin falling edges
// - mode 0 is high byte plus low five bits, divide-by-32 prescaler
// - mode 2 runs low byte, sets flag and reloads from unchanged high byte
// - with gate set, timer counts only while irq pin high and run bit set
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module dual_timer_counter_control
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       reset_pin,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_irq_pin_a,
  input  wire logic       ext_irq_pin_b,
  input  wire logic       count_pin_a,
  input  wire logic       count_pin_b,
  input  wire logic       irq0_ack,
  input  wire logic       irq1_ack,
  input  wire logic       timer0_ack,
  input  wire logic       timer1_ack,
  output logic            irq0_request,
  output logic            irq1_request,
  output logic            internal_reset
);

  // ----------------------------------------------------------------
  // reset pin qualification and machine cycle
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RST_IDLE = 2'b01, RST_HOLD = 2'b10} rst_state_t;

  logic       rpin_meta_reg;
  logic       rpin_sync_reg;
  logic [4:0] rcnt_reg;
  logic [4:0] rcnt_next;
  rst_state_t rst_state_reg;
  rst_state_t rst_state_next;
  logic       ireset_reg;
  logic       ireset_next;
  logic [3:0] phase_reg;
  logic [3:0] phase_next;
  logic       mtick;

  assign mtick = (phase_reg == dual_timer_pkg::MCYCLE_LAST);

  // internal reset asserts once the synchronised pin has been high 12 oscillator periods
  always_comb
  begin
    rcnt_next      = rcnt_reg;
    rst_state_next = rst_state_reg;
    ireset_next    = 1'b0;
    phase_next     = mtick ? 4'h0 : phase_reg + 4'h1;
    case (rst_state_reg)
      RST_IDLE:
      begin
        rcnt_next = 5'h00;
        if (rpin_sync_reg)
          rst_state_next = RST_HOLD;
      end
      RST_HOLD:
      begin
        if (!rpin_sync_reg)
          rst_state_next = RST_IDLE;
        else if (rcnt_reg != dual_timer_pkg::RESET_CNT_LAST)
          rcnt_next = rcnt_reg + 5'h01;
        // hold internal reset through the second machine cycle and beyond
        if (rpin_sync_reg && rcnt_reg >= 5'(dual_timer_pkg::OSC_PER_MCYCLE - 1))
          ireset_next = 1'b1;
      end
      default: rst_state_next = RST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rpin_meta_reg <= 1'b0;
      rpin_sync_reg <= 1'b0;
      rcnt_reg      <= 5'h00;
      rst_state_reg <= RST_IDLE;
      ireset_reg    <= 1'b0;
      phase_reg     <= 4'h0;
    end
    else
    begin
      rpin_meta_reg <= reset_pin;
      rpin_sync_reg <= rpin_meta_reg;
      rcnt_reg      <= rcnt_next;
      rst_state_reg <= rst_state_next;
      ireset_reg    <= ireset_next;
      phase_reg     <= phase_next;
    end
  end

  // ----------------------------------------------------------------
  // pin sensing
  // ----------------------------------------------------------------
  logic irq_a_level;
  logic irq_a_fall;
  logic irq_b_level;
  logic irq_b_fall;
  logic cnt_a_fall;
  logic cnt_b_fall;

  pin_edge_sense u_irq_a (.clock(clock), .rst_b(rst_b), .pin_in(ext_irq_pin_a), .sample_tick(mtick),
                          .level_out(irq_a_level), .fall_pulse(irq_a_fall));
  pin_edge_sense u_irq_b (.clock(clock), .rst_b(rst_b), .pin_in(ext_irq_pin_b), .sample_tick(mtick),
                          .level_out(irq_b_level), .fall_pulse(irq_b_fall));
  pin_edge_sense u_cnt_a (.clock(clock), .rst_b(rst_b), .pin_in(count_pin_a), .sample_tick(mtick),
                          .level_out(), .fall_pulse(cnt_a_fall));
  pin_edge_sense u_cnt_b (.clock(clock), .rst_b(rst_b), .pin_in(count_pin_b), .sample_tick(mtick),
                          .level_out(), .fall_pulse(cnt_b_fall));

  // ----------------------------------------------------------------
  // registers and counting
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] t0_low_reg;
  logic [7:0] t0_low_next;
  logic [7:0] t0_high_reg;
  logic [7:0] t0_high_next;
  logic [7:0] t1_low_reg;
  logic [7:0] t1_low_next;
  logic [7:0] t1_high_reg;
  logic [7:0] t1_high_next;
  logic [7:0] rdata_next;
  logic       irq0_req_next;
  logic       irq1_req_next;

  // one timer step: returns {overflow, high, low}
  function automatic logic [16:0] timer_step(input logic [1:0] mode, input logic [7:0] hi,
                                             input logic [7:0] lo);
    logic [16:0] res;
    logic [8:0]  lsum;
    logic [8:0]  hsum;
    res  = {1'b0, hi, lo};
    lsum = 9'h000;
    hsum = 9'h000;
    case (mode)
      dual_timer_pkg::MODE_13BIT:
      begin
        // low five bits prescale by 32; upper three low bits left alone
        lsum = {4'h0, lo[4:0]} + 9'h001;
        if (lsum[5])
        begin
          hsum = {1'b0, hi} + 9'h001;
          res  = {hsum[8], hsum[7:0], lo[7:5], 5'h00};
        end
        else
          res = {1'b0, hi, lo[7:5], lsum[4:0]};
      end
      dual_timer_pkg::MODE_RELOAD:
      begin
        lsum = {1'b0, lo} + 9'h001;
        // reload from high byte, high byte untouched
        res  = lsum[8] ? {1'b1, hi, hi} : {1'b0, hi, lsum[7:0]};
      end
      default:
      begin
        // 16-bit count; split-mode low byte handled by caller
        res = {1'b0, hi, lo} + 17'h00001;
      end
    endcase
    return res;
  endfunction

  // count enable: run bit, gate and timer/counter source
  function automatic logic count_enable(input logic [3:0] nib, input logic run, input logic gate_pin,
                                        input logic tick, input logic pin_fall);
    logic ok;
    ok = run & (~nib[dual_timer_pkg::MODE_GATE_BIT] | gate_pin);
    return ok & (nib[dual_timer_pkg::MODE_COUNTER_BIT] ? pin_fall : tick);
  endfunction

  always_comb
  begin
    logic [3:0]  nib0;
    logic [3:0]  nib1;
    logic        split;
    logic        en0;
    logic        en0h;
    logic        en1;
    logic [16:0] s0;
    logic [16:0] s1;
    logic [8:0]  b9;
    logic        set_tf0;
    logic        set_tf1;
    logic        set_ie0;
    logic        set_ie1;
    nib0    = mode_reg[3:0];
    nib1    = mode_reg[7:4];
    split   = (nib0[1:0] == dual_timer_pkg::MODE_SPLIT);
    en0     = count_enable(nib0, ctrl_reg[dual_timer_pkg::BIT_T0_RUN], irq_a_level, mtick, cnt_a_fall);
    // split mode: high byte is a timer only, run by timer 1 run bit
    en0h    = split & ctrl_reg[dual_timer_pkg::BIT_T1_RUN] & mtick;
    // own mode 3 holds timer 1; while split, its run bit belongs to timer 0 high
    en1     = (nib1[1:0] != dual_timer_pkg::MODE_SPLIT) &
              count_enable(nib1, split | ctrl_reg[dual_timer_pkg::BIT_T1_RUN], irq_b_level, mtick, cnt_b_fall);
    s0      = 17'h00000;
    s1      = 17'h00000;
    b9      = 9'h000;
    set_tf0 = 1'b0;
    set_tf1 = 1'b0;
    set_ie0 = ctrl_reg[dual_timer_pkg::BIT_IRQ0_TYPE] & irq_a_fall;
    set_ie1 = ctrl_reg[dual_timer_pkg::BIT_IRQ1_TYPE] & irq_b_fall;
    ctrl_next    = ctrl_reg;
    mode_next    = mode_reg;
    t0_low_next  = t0_low_reg;
    t0_high_next = t0_high_reg;
    t1_low_next  = t1_low_reg;
    t1_high_next = t1_high_reg;
    rdata_next   = 8'h00;

    // software access to separate bytes
    if (reg_write)
    begin
      if (reg_addr == dual_timer_pkg::OFF_CONTROL)
        ctrl_next = reg_wdata;
      else if (reg_addr == dual_timer_pkg::OFF_MODE)
        mode_next = reg_wdata;
      else if (reg_addr == dual_timer_pkg::OFF_T0_LOW)
        t0_low_next = reg_wdata;
      else if (reg_addr == dual_timer_pkg::OFF_T0_HIGH)
        t0_high_next = reg_wdata;
      else if (reg_addr == dual_timer_pkg::OFF_T1_LOW)
        t1_low_next = reg_wdata;
      else if (reg_addr == dual_timer_pkg::OFF_T1_HIGH)
        t1_high_next = reg_wdata;
    end
    if (reg_read)
    begin
      if (reg_addr == dual_timer_pkg::OFF_CONTROL)
        rdata_next = ctrl_reg;
      else if (reg_addr == dual_timer_pkg::OFF_MODE)
        rdata_next = mode_reg;
      else if (reg_addr == dual_timer_pkg::OFF_T0_LOW)
        rdata_next = t0_low_reg;
      else if (reg_addr == dual_timer_pkg::OFF_T0_HIGH)
        rdata_next = t0_high_reg;
      else if (reg_addr == dual_timer_pkg::OFF_T1_LOW)
        rdata_next = t1_low_reg;
      else if (reg_addr == dual_timer_pkg::OFF_T1_HIGH)
        rdata_next = t1_high_reg;
    end

    // counting overrides a same-cycle byte write to the counting register
    if (split)
    begin
      if (en0)
      begin
        b9          = {1'b0, t0_low_reg} + 9'h001;
        t0_low_next = b9[7:0];
        set_tf0     = b9[8];
      end
      if (en0h)
      begin
        b9           = {1'b0, t0_high_reg} + 9'h001;
        t0_high_next = b9[7:0];
        set_tf1      = b9[8];
      end
    end
    else if (en0)
    begin
      s0           = timer_step(nib0[1:0], t0_high_reg, t0_low_reg);
      t0_high_next = s0[15:8];
      t0_low_next  = s0[7:0];
      set_tf0      = s0[16];
    end
    if (en1)
    begin
      s1           = timer_step(nib1[1:0], t1_high_reg, t1_low_reg);
      t1_high_next = s1[15:8];
      t1_low_next  = s1[7:0];
      set_tf1      = set_tf1 | (~split & s1[16]);
    end

    // edge flags only in edge mode; level mode requests follow the pin
    if (irq0_ack && ctrl_reg[dual_timer_pkg::BIT_IRQ0_TYPE])
      ctrl_next[dual_timer_pkg::BIT_IRQ0_EDGE] = 1'b0;
    if (irq1_ack && ctrl_reg[dual_timer_pkg::BIT_IRQ1_TYPE])
      ctrl_next[dual_timer_pkg::BIT_IRQ1_EDGE] = 1'b0;
    if (timer0_ack)
      ctrl_next[dual_timer_pkg::BIT_T0_OVF] = 1'b0;
    if (timer1_ack)
      ctrl_next[dual_timer_pkg::BIT_T1_OVF] = 1'b0;
    // hardware sets applied last so they beat any clear
    if (set_ie0)
      ctrl_next[dual_timer_pkg::BIT_IRQ0_EDGE] = 1'b1;
    if (set_ie1)
      ctrl_next[dual_timer_pkg::BIT_IRQ1_EDGE] = 1'b1;
    if (set_tf0)
      ctrl_next[dual_timer_pkg::BIT_T0_OVF] = 1'b1;
    if (set_tf1)
      ctrl_next[dual_timer_pkg::BIT_T1_OVF] = 1'b1;

    irq0_req_next = ctrl_next[dual_timer_pkg::BIT_IRQ0_TYPE] ? ctrl_next[dual_timer_pkg::BIT_IRQ0_EDGE]
                                                            : ~irq_a_level;
    irq1_req_next = ctrl_next[dual_timer_pkg::BIT_IRQ1_TYPE] ? ctrl_next[dual_timer_pkg::BIT_IRQ1_EDGE]
                                                            : ~irq_b_level;
  end

  // internal reset clears everything synchronously to zero
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_reg     <= dual_timer_pkg::RESET_BYTE;
      mode_reg     <= dual_timer_pkg::RESET_BYTE;
      t0_low_reg   <= dual_timer_pkg::RESET_BYTE;
      t0_high_reg  <= dual_timer_pkg::RESET_BYTE;
      t1_low_reg   <= dual_timer_pkg::RESET_BYTE;
      t1_high_reg  <= dual_timer_pkg::RESET_BYTE;
      reg_rdata    <= 8'h00;
      irq0_request <= 1'b0;
      irq1_request <= 1'b0;
    end
    else if (ireset_reg)
    begin
      ctrl_reg     <= dual_timer_pkg::RESET_BYTE;
      mode_reg     <= dual_timer_pkg::RESET_BYTE;
      t0_low_reg   <= dual_timer_pkg::RESET_BYTE;
      t0_high_reg  <= dual_timer_pkg::RESET_BYTE;
      t1_low_reg   <= dual_timer_pkg::RESET_BYTE;
      t1_high_reg  <= dual_timer_pkg::RESET_BYTE;
      reg_rdata    <= 8'h00;
      irq0_request <= 1'b0;
      irq1_request <= 1'b0;
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      mode_reg     <= mode_next;
      t0_low_reg   <= t0_low_next;
      t0_high_reg  <= t0_high_next;
      t1_low_reg   <= t1_low_next;
      t1_high_reg  <= t1_high_next;
      reg_rdata    <= rdata_next;
      irq0_request <= irq0_req_next;
      irq1_request <= irq1_req_next;
    end
  end

  assign internal_reset = ireset_reg;

endmodule // dual_timer_counter_control

/* core/dual_timer_pkg.sv */
// package: register map, field positions, reset values and timing for the dual timer block
package dual_timer_pkg;

  // ----------------------------------------------------------------
  // register offsets (chosen; no offsets are printed)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_CONTROL = 3'h0;
  localparam logic [2:0] OFF_MODE    = 3'h1;
  localparam logic [2:0] OFF_T0_LOW  = 3'h2;
  localparam logic [2:0] OFF_T0_HIGH = 3'h3;
  localparam logic [2:0] OFF_T1_LOW  = 3'h4;
  localparam logic [2:0] OFF_T1_HIGH = 3'h5;

  // ----------------------------------------------------------------
  // control/status field positions
  // ----------------------------------------------------------------
  localparam int BIT_IRQ0_TYPE = 0;
  localparam int BIT_IRQ0_EDGE = 1;
  localparam int BIT_IRQ1_TYPE = 2;
  localparam int BIT_IRQ1_EDGE = 3;
  localparam int BIT_T0_RUN    = 4;
  localparam int BIT_T0_OVF    = 5;
  localparam int BIT_T1_RUN    = 6;
  localparam int BIT_T1_OVF    = 7;

  // mode nibble layout: [1:0] mode, [2] counter select, [3] gate
  localparam int MODE_GATE_BIT    = 3;
  localparam int MODE_COUNTER_BIT = 2;
  localparam int T1_NIBBLE_POS    = 4;

  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam int         OSC_PER_MCYCLE  = 12;
  localparam int         RESET_MCYCLES   = 2;
  localparam int         RESET_OSC_COUNT = OSC_PER_MCYCLE * RESET_MCYCLES;
  localparam logic [4:0] RESET_CNT_LAST  = 5'(RESET_OSC_COUNT - 1);
  localparam logic [3:0] MCYCLE_LAST     = 4'(OSC_PER_MCYCLE - 1);

endpackage

/* core/pin_edge_sense.sv */
// module: two-stage pin synchroniser with per-machine-cycle sampling and falling-edge detect
`timescale 1ns/100ps
module pin_edge_sense
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic pin_in,
  input  wire logic sample_tick,
  output logic      level_out,
  output logic      fall_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic sample_reg;
  logic sample_next;
  logic fall_reg;
  logic fall_next;

  // sample once per machine cycle, so an edge shows at the first sample after it reaches sync_reg
  always_comb
  begin
    sample_next = sample_reg;
    fall_next   = 1'b0;
    if (sample_tick)
    begin
      sample_next = sync_reg;
      fall_next   = sample_reg & ~sync_reg;
    end
  end

  // pins idle high; reset to high avoids a false edge after release
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg   <= 1'b1;
      sync_reg   <= 1'b1;
      sample_reg <= 1'b1;
      fall_reg   <= 1'b0;
    end
    else
    begin
      meta_reg   <= pin_in;
      sync_reg   <= meta_reg;
      sample_reg <= sample_next;
      fall_reg   <= fall_next;
    end
  end

  assign level_out  = sample_reg;
  assign fall_pulse = fall_reg;
endmodule // pin_edge_sense

/* sim/pin_drive_model.sv */
// partner model: external count and interrupt pins with a minimum time at each level
`timescale 1ns/100ps
module pin_drive_model
#(
  parameter int HOLD = 12
)
(
  input  wire logic       clock,
  input  wire logic [3:0] want,
  output logic      [3:0] pins
);
  int age [4];
  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // idle high like a pulled-up port pin; a level is held at least one machine
  // cycle so the block never meets a pulse shorter than its sample period
  initial
  begin
    pins = 4'hF;
    for (int i = 0; i < 4; i++)
      age[i] = 0;
  end
  always @(posedge clock)
    for (int i = 0; i < 4; i++)
      if (pins[i] != want[i] && age[i] >= HOLD)
      begin
        pins[i] <= want[i];
        age[i] <= 0;
      end
      else
        age[i] <= age[i] + 1;
endmodule // pin_drive_model

/* sim/dual_timer_counter_control_assertions.sv */
// checker: port-level assertions for the dual timer block
`timescale 1ns/100ps
module dual_timer_counter_control_assertions
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       reset_pin,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       ext_irq_pin_a,
  input wire logic       ext_irq_pin_b,
  input wire logic       irq0_request,
  input wire logic       irq1_request,
  input wire logic       internal_reset
);
  logic [5:0] rp_cnt_reg, rp_cnt_next, lo_a_reg, lo_a_next, lo_b_reg, lo_b_next;
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  // saturating: time reset pin is high, time since each irq pin was low
  always_comb
  begin
    rp_cnt_next = reset_pin ? rp_cnt_reg + 6'(rp_cnt_reg != 6'h3F) : 6'h00;
    lo_a_next = ext_irq_pin_a ? lo_a_reg + 6'(lo_a_reg != 6'h3F) : 6'h00;
    lo_b_next = ext_irq_pin_b ? lo_b_reg + 6'(lo_b_reg != 6'h3F) : 6'h00;
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rp_cnt_reg <= 6'h00;
      lo_a_reg <= 6'h3F;
      lo_b_reg <= 6'h3F;
    end
    else
    begin
      rp_cnt_reg <= rp_cnt_next;
      lo_a_reg <= lo_a_next;
      lo_b_reg <= lo_b_next;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_rdata_unmapped: assert property ($past(reg_read) && $past(reg_addr) > 3'h5 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mode_readback: assert property ($past(reg_write, 2) && $past(reg_read)
    && $past(reg_addr, 2) == 3'h1 && $past(reg_addr) == 3'h1 && !$past(internal_reset)
    && !$past(internal_reset, 2) |-> reg_rdata == $past(reg_wdata, 2))
    else $error("mode register read back wrong");
  a_intreset_clears: assert property ($past(internal_reset, 2) && $past(internal_reset)
    && $past(reg_read) |-> reg_rdata == 8'h00)
    else $error("register not zero under internal reset");
  a_rst_outputs_zero: assert property ($rose(rst_b) |-> reg_rdata == 8'h00
    && !irq0_request && !irq1_request && !internal_reset)
    else $error("outputs not zero after reset release");
  a_intreset_late: assert property ($rose(internal_reset) |-> rp_cnt_reg >= 6'd12)
    else $error("internal reset before second machine cycle");
  a_intreset_bound: assert property (rp_cnt_reg == 6'd32 |-> internal_reset)
    else $error("internal reset missing with pin held");
  a_intreset_release: assert property ($fell(reset_pin) |-> ##[1:6] !internal_reset)
    else $error("internal reset stuck after pin release");
  a_irq0_cause: assert property ($rose(irq0_request) |-> lo_a_reg <= 6'd30)
    else $error("irq0 request without low pin");
  a_irq1_cause: assert property ($rose(irq1_request) |-> lo_b_reg <= 6'd30)
    else $error("irq1 request without low pin");
endmodule // dual_timer_counter_control_assertions

bind dual_timer_counter_control dual_timer_counter_control_assertions i_chk
(
  .clock(clock), .rst_b(rst_b), .reset_pin(reset_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .ext_irq_pin_a(ext_irq_pin_a),
  .ext_irq_pin_b(ext_irq_pin_b), .irq0_request(irq0_request), .irq1_request(irq1_request),
  .internal_reset(internal_reset)
);

/* sim/dual_timer_counter_control_tb.sv */
// testbench: register, timer, pin and reset scenarios for the dual timer block
`timescale 1ns/100ps
module dual_timer_counter_control_tb;
  logic       clock, rst_b, reset_pin, reg_write, reg_read, internal_reset;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd, v;
  logic [1:0] iack, tack, req;
  logic [3:0] want, pins;
  int         n_fail, samples_checked, cycles;
  pin_drive_model #(.HOLD(12)) i_pins (.clock(clock), .want(want), .pins(pins));
  dual_timer_counter_control i_dut
  (
    .clock(clock), .rst_b(rst_b), .reset_pin(reset_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .ext_irq_pin_a(pins[0]),
    .ext_irq_pin_b(pins[1]), .count_pin_a(pins[2]), .count_pin_b(pins[3]), .irq0_ack(iack[0]),
    .irq1_ack(iack[1]), .timer0_ack(tack[0]), .timer1_ack(tack[1]), .irq0_request(req[0]),
    .irq1_request(req[1]), .internal_reset(internal_reset)
  );
  // ------------------------------------------------------------
  // bus and check tasks (offsets: 0 control, 1 mode, 2/3 t0 lo/hi, 4/5 t1 lo/hi)
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // data stands only in the cycle after the read edge; taken at the edge closing it, before it clears
  task automatic rdr(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
  task automatic chk_in(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    samples_checked++;
    if (!(got >= lo && got <= hi) || $isunknown(got))
    begin
      n_fail++;
      $display("BAD %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    chk_in(got, exp, exp);
  endtask
  // bounded poll of one control bit
  task automatic poll(input int b);
    rd = 8'h00;
    for (int i = 0; i < 40 && rd[b] !== 1'b1; i++)
      rdr(3'h0, rd);
    chk({7'h00, rd[b]}, 8'h01);
  endtask
  task automatic count_fall;
    want[2] <= 1'b0;
    tick(50);
    want[2] <= 1'b1;
    tick(50);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    for (int a = 0; a < 8; a++)
    begin
      rdr(3'(a), rd);
      chk(rd, 8'h00);
    end
    for (int a = 2; a < 7; a++)
      wr(3'(a), 8'(a * 17));
    for (int a = 2; a < 7; a++)
    begin
      rdr(3'(a), rd);
      chk(rd, (a == 6) ? 8'h00 : 8'(a * 17));
    end
    // write then read with no gap, as the bus allows
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= 3'h1;
    reg_wdata <= 8'h5A;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    chk(reg_rdata, 8'h5A);
  endtask
  task automatic t_timer;
    wr(3'h1, 8'h01);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h10);
    tick(120);
    wr(3'h0, 8'h00);
    rdr(3'h2, v);
    chk_in(v, 8'h0A, 8'h0B);
    tick(40);
    rdr(3'h2, rd);
    chk(rd, v);
    wr(3'h3, 8'hFF);
    wr(3'h2, 8'hFE);
    wr(3'h0, 8'h10);
    poll(5);
    rdr(3'h3, rd);
    chk(rd, 8'h00);
    wr(3'h0, 8'h20);
    tick(40);
    rdr(3'h0, rd);
    chk(rd, 8'h20);
    tack[0] <= 1'b1;
    tick(1);
    tack[0] <= 1'b0;
    rdr(3'h0, rd);
    chk(rd, 8'h00);
  endtask
  task automatic t_modes;
    wr(3'h1, 8'h00);
    wr(3'h3, 8'hFF);
    wr(3'h2, 8'h1E);
    wr(3'h0, 8'h10);
    poll(5);
    rdr(3'h3, rd);
    chk(rd, 8'h00);
    wr(3'h1, 8'h20);
    wr(3'h5, 8'hFD);
    wr(3'h4, 8'hFD);
    wr(3'h0, 8'h40);
    poll(7);
    rdr(3'h5, rd);
    chk(rd, 8'hFD);
    rdr(3'h4, rd);
    chk_in(rd, 8'hFD, 8'hFE);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h33);
    wr(3'h3, 8'hFF);
    wr(3'h2, 8'h55);
    wr(3'h4, 8'h77);
    wr(3'h0, 8'h40);
    poll(7);
    rdr(3'h0, rd);
    chk(rd, 8'hC0);
    rdr(3'h2, rd);
    chk(rd, 8'h55);
    rdr(3'h4, rd);
    chk(rd, 8'h77);
    tack[1] <= 1'b1;
    tick(1);
    tack[1] <= 1'b0;
    rdr(3'h0, rd);
    chk(rd, 8'h40);
    wr(3'h0, 8'h00);
  endtask
  task automatic t_irq;
    for (int i = 0; i < 2; i++)
    begin
      wr(3'h0, 8'h01 << (2 * i));
      want[i] <= 1'b0;
      tick(50);
      want[i] <= 1'b1;
      tick(50);
      chk({7'h00, req[i]}, 8'h01);
      rdr(3'h0, rd);
      chk(rd, 8'h03 << (2 * i));
      iack[i] <= 1'b1;
      tick(1);
      iack[i] <= 1'b0;
      tick(3);
      chk({7'h00, req[i]}, 8'h00);
      wr(3'h0, 8'h00);
      want[i] <= 1'b0;
      tick(50);
      chk({7'h00, req[i]}, 8'h01);
      want[i] <= 1'b1;
      tick(50);
      chk({7'h00, req[i]}, 8'h00);
    end
  endtask
  task automatic t_gate;
    wr(3'h1, 8'h0D);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h10);
    want[0] <= 1'b0;
    tick(50);
    count_fall;
    rdr(3'h2, rd);
    chk(rd, 8'h00);
    want[0] <= 1'b1;
    tick(50);
    count_fall;
    rdr(3'h2, rd);
    chk(rd, 8'h01);
  endtask
  task automatic t_reset_pin;
    wr(3'h5, 8'hAA);
    reset_pin <= 1'b1;
    tick(10);
    chk({7'h00, internal_reset}, 8'h00);
    tick(30);
    chk({7'h00, internal_reset}, 8'h01);
    rdr(3'h5, rd);
    chk(rd, 8'h00);
    reset_pin <= 1'b0;
    tick(8);
    chk({7'h00, internal_reset}, 8'h00);
    for (int a = 0; a < 6; a++)
    begin
      rdr(3'(a), rd);
      chk(rd, 8'h00);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // the whole run needs about 1250 cycles; a hang ends it at 40000, some 30 times that
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      end_sim;
    end
  end
  initial
  begin
    {rst_b, reset_pin, reg_write, reg_read, reg_addr, reg_wdata, iack, tack} = '0;
    want = 4'hF;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    tick(2);
    rst_b <= 1'b1;
    t_regs;
    t_timer;
    t_modes;
    t_irq;
    t_gate;
    t_reset_pin;
    end_sim;
  end
endmodule // dual_timer_counter_control_tb
